// *** hdl/epc_pkg.sv ***
/*
 Constants, opcodes, status layout and decoder states of the serial EEPROM front end.
 Assumes a 10 MHz system clock that oversamples every serial pin.
*/
package epc_pkg;
   // System clock period and the internal write cycle time.
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_WC_MS = 5;
   localparam int NS_PER_MS = 1000000;
   localparam int WC_CYCLES_DEF = T_WC_MS * NS_PER_MS / CLK_PERIOD_NS;
   // Instruction bytes.
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   // Status register field positions.
   localparam int SR_HONOR = 7;
   localparam int SR_BP1 = 3;
   localparam int SR_BP0 = 2;
   localparam int SR_WEL = 1;
   localparam int SR_WIP = 0;
   localparam logic [1:0] BP_RESET = 2'h0;
   // Synchroniser reset: chip select, serial clock, serial input, pause, protect.
   localparam logic [4:0] SYNC_RESET = 5'h13;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] NB_ONE = 2'h1;
   localparam logic [1:0] NB_MAX = 2'h3;
   typedef enum logic [2:0] {
      ST_INSTR, ST_ADDR, ST_DATA_IN, ST_STATUS_IN, ST_DATA_OUT, ST_IGNORE
   } epc_state_t;
endpackage

// *** hdl/epc_front.sv ***
/*
 Serial front end of a small serial EEPROM: select, shift, pause, protect and write timing.
 Assumes the memory array sits outside and answers arr_rdata_in within one clock of
 arr_addr_out, and that the serial clock is far slower than clk_sys_in.
*/
// Functional notes
// RULE_01: Chip select low selects; high deselects into standby.
// RULE_02: A started programming cycle completes; standby comes only afterwards.
// RULE_03: Serial output floats whenever deselected.
// RULE_04: Chip select rising after a valid write sequence starts the write cycle.
// RULE_05: The write cycle lasts at most 5 ms from that rising edge.
// RULE_06: Host drives chip select low after power-up before any command.
// RULE_07: Read data bits change after each serial clock falling edge.
// RULE_08: Input bits are captured on each serial clock rising edge.
// RULE_09: Protect pin low with honor bit set refuses status writes.
// RULE_10: Protect pin changes after a write cycle began do not affect it.
// RULE_11: With honor bit clear the protect pin is ignored.
// RULE_12: Pause suspends the transfer without reset; release continues at that bit.
// RULE_13: Pause applies at once with clock low, else at next falling edge.
// RULE_14: Resume applies at once with clock low, else at next falling edge.
// RULE_15: While paused, serial input and clock are ignored.
// RULE_16: Host keeps select low while paused and pause high when unused.
// RULE_17: Output floats at once on pause fall and drives on pause rise.
// RULE_18: All bytes travel most significant bit first.
// RULE_19: Host keeps select low and pause high for a whole operation.
// RULE_20: Select rising on an incomplete or other sequence returns to idle.
`timescale 1ns/1ns
module epc_front #(
   parameter int WC_CYCLES = epc_pkg::WC_CYCLES_DEF,
   parameter int ADDR_W = 15,
   parameter int PAGE_BYTES = 64
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   output logic so_out,
   output logic so_oe_out,
   output logic standby_out,
   output logic busy_out,
   output logic [ADDR_W-1:0] arr_addr_out,
   input wire logic [7:0] arr_rdata_in,
   output logic [7:0] arr_wdata_out,
   output logic arr_wr_out,
   output logic arr_commit_out
);
   import epc_pkg::*;

   localparam int PB = $clog2(PAGE_BYTES);
   localparam int CNT_W = $clog2(WC_CYCLES + 1);

   // Refuse shapes that the page wrap or the counter cannot serve.
   if (PAGE_BYTES < 2 || (1 << PB) != PAGE_BYTES || ADDR_W > 16 || ADDR_W <= PB ||
       WC_CYCLES < 2) begin : g_bad_params
      $error("epc_front: unsupported parameter values");
   end

   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic sck_d_ff;
   logic cs_d_ff;
   logic paused_ff;
   epc_state_t state_ff;
   logic [7:0] rx_shift_ff;
   logic [2:0] bitcnt_ff;
   logic [7:0] op_ff;
   logic [15:0] addr_ff;
   logic addr_hi_ff;
   logic [1:0] nbytes_ff;
   logic [7:0] sr_pend_ff;
   logic load_pend_ff;
   logic [7:0] tx_byte_ff;
   logic so_ff;
   logic out_en_ff;
   logic wip_ff;
   logic wel_ff;
   logic honor_ff;
   logic [1:0] bp_ff;
   logic commit_sr_ff;
   logic [CNT_W-1:0] wc_cnt_ff;
   logic arr_wr_ff;
   logic [7:0] wdata_ff;
   logic commit_ff;

   // Two flip-flops on every pin; only the second stage is read.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_ff <= SYNC_RESET;
         sync_ff <= SYNC_RESET;
      end else begin
         meta_ff <= {cs_n_in, sck_in, si_in, hold_n_in, wp_n_in};
         sync_ff <= meta_ff;
      end
   end

   logic cs_s, sck_s, si_s, hold_s, wp_s;
   assign {cs_s, sck_s, si_s, hold_s, wp_s} = sync_ff;

   // Edge history; chip select resets high so a low level must be seen first.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sck_d_ff <= 1'b0;
         cs_d_ff <= 1'b1; // [RULE_06]
      end else begin
         sck_d_ff <= sck_s;
         cs_d_ff <= cs_s;
      end
   end

   logic selected, sck_rise, sck_fall, cs_rise, act_rise, act_fall, byte_done;
   logic [7:0] nxt_shift;
   assign selected = ~cs_s; // [RULE_01]
   assign sck_rise = sck_s & ~sck_d_ff;
   assign sck_fall = ~sck_s & sck_d_ff;
   assign cs_rise = cs_s & ~cs_d_ff;
   assign act_rise = sck_rise & selected & ~paused_ff; // [RULE_15]
   assign act_fall = sck_fall & selected & ~paused_ff; // [RULE_15]
   assign byte_done = act_rise & (bitcnt_ff == BIT_LAST);
   assign nxt_shift = {rx_shift_ff[6:0], si_s}; // [RULE_18]

   // Pause follows the pin only while the clock is low, which covers both the
   // immediate case and the wait for the next falling edge.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         paused_ff <= 1'b0;
      end else if (cs_s) begin
         paused_ff <= 1'b0;
      end else if (~sck_s && (paused_ff == hold_s)) begin
         paused_ff <= ~hold_s; // [RULE_13] [RULE_14]
      end
   end

   // Serial decoder; pausing only freezes it, so the sequence resumes at the same bit.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff <= ST_INSTR;
         rx_shift_ff <= 8'h00;
         bitcnt_ff <= 3'h0;
         op_ff <= 8'h00;
         addr_ff <= 16'h0000;
         addr_hi_ff <= 1'b0;
         nbytes_ff <= 2'h0;
         sr_pend_ff <= 8'h00;
         load_pend_ff <= 1'b0;
      end else if (cs_s) begin
         state_ff <= ST_INSTR; // [RULE_20]
         bitcnt_ff <= 3'h0;
         addr_hi_ff <= 1'b0;
         nbytes_ff <= 2'h0;
         load_pend_ff <= 1'b0;
      end else begin
         load_pend_ff <= 1'b0;
         if (act_rise) begin
            rx_shift_ff <= nxt_shift; // [RULE_08] [RULE_12]
            bitcnt_ff <= bitcnt_ff + 3'h1;
         end
         if (byte_done) begin
            unique case (state_ff)
               ST_INSTR: begin
                  op_ff <= nxt_shift;
                  if (nxt_shift == OP_RDSR) begin
                     state_ff <= ST_DATA_OUT;
                     load_pend_ff <= 1'b1;
                  end else if ((nxt_shift == OP_READ || nxt_shift == OP_WRITE) && !wip_ff) begin
                     state_ff <= ST_ADDR;
                  end else if (nxt_shift == OP_WRSR && !wip_ff) begin
                     state_ff <= ST_STATUS_IN;
                  end else begin
                     state_ff <= ST_IGNORE;
                  end
               end
               ST_ADDR: begin
                  addr_ff <= {addr_ff[7:0], nxt_shift};
                  addr_hi_ff <= ~addr_hi_ff;
                  if (addr_hi_ff) begin
                     state_ff <= (op_ff == OP_READ) ? ST_DATA_OUT : ST_DATA_IN;
                     load_pend_ff <= (op_ff == OP_READ);
                  end
               end
               ST_DATA_IN: begin
                  // Writes wrap inside the page instead of spilling into the next one.
                  addr_ff[PB-1:0] <= addr_ff[PB-1:0] + PB'(1);
                  if (nbytes_ff != NB_MAX) nbytes_ff <= nbytes_ff + 2'h1;
               end
               ST_STATUS_IN: begin
                  sr_pend_ff <= nxt_shift;
                  if (nbytes_ff != NB_MAX) nbytes_ff <= nbytes_ff + 2'h1;
               end
               ST_DATA_OUT: begin
                  if (op_ff == OP_READ) addr_ff <= addr_ff + 16'h0001;
                  load_pend_ff <= 1'b1;
               end
               ST_IGNORE: begin
                  if (nbytes_ff != NB_MAX) nbytes_ff <= nbytes_ff + 2'h1;
               end
            endcase
         end
      end
   end

   // One strobe per complete data byte towards the external page buffer.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         arr_wr_ff <= 1'b0;
         wdata_ff <= 8'h00;
      end else begin
         arr_wr_ff <= byte_done && state_ff == ST_DATA_IN && !cs_s;
         if (byte_done && state_ff == ST_DATA_IN) wdata_ff <= nxt_shift;
      end
   end

   logic [7:0] status_rd;
   assign status_rd = {honor_ff, 3'h0, bp_ff, wel_ff, wip_ff};

   // Output byte is fetched after the rising edge that ends the previous byte and
   // shifted out on falling edges, so it is stable long before the next rise.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tx_byte_ff <= 8'h00;
         so_ff <= 1'b0;
         out_en_ff <= 1'b0;
      end else if (cs_s) begin
         out_en_ff <= 1'b0;
      end else begin
         if (load_pend_ff) tx_byte_ff <= (op_ff == OP_RDSR) ? status_rd : arr_rdata_in;
         if (act_fall && state_ff == ST_DATA_OUT && !load_pend_ff) begin
            so_ff <= tx_byte_ff[3'(BIT_LAST - bitcnt_ff)]; // [RULE_07] [RULE_18]
            out_en_ff <= 1'b1;
         end
      end
   end

   logic write_ok, wrsr_ok, protect_hit, wc_last;
   assign protect_hit = honor_ff & ~wp_s; // [RULE_09] [RULE_11]
   assign write_ok = cs_rise && !wip_ff && wel_ff && op_ff == OP_WRITE &&
                     state_ff == ST_DATA_IN && bitcnt_ff == 3'h0 && nbytes_ff != 2'h0;
   assign wrsr_ok = cs_rise && !wip_ff && wel_ff && !protect_hit && op_ff == OP_WRSR &&
                    state_ff == ST_STATUS_IN && bitcnt_ff == 3'h0 && nbytes_ff == NB_ONE;
   assign wc_last = wip_ff && wc_cnt_ff == CNT_W'(WC_CYCLES - 1);

   // Write cycle timer runs on the system clock, blind to select and protect pins.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wip_ff <= 1'b0;
         wc_cnt_ff <= '0;
         commit_sr_ff <= 1'b0;
         commit_ff <= 1'b0;
      end else begin
         commit_ff <= write_ok;
         if (write_ok || wrsr_ok) begin
            wip_ff <= 1'b1; // [RULE_04]
            wc_cnt_ff <= '0;
            commit_sr_ff <= wrsr_ok; // [RULE_10]
         end else if (wc_last) begin
            wip_ff <= 1'b0; // [RULE_05] [RULE_02]
         end else if (wip_ff) begin
            wc_cnt_ff <= wc_cnt_ff + CNT_W'(1);
         end
      end
   end

   // Enable latch and nonvolatile status bits.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wel_ff <= 1'b0;
         honor_ff <= 1'b0;
         bp_ff <= BP_RESET;
      end else if (wc_last) begin
         wel_ff <= 1'b0;
         if (commit_sr_ff) begin
            honor_ff <= sr_pend_ff[SR_HONOR];
            bp_ff <= {sr_pend_ff[SR_BP1], sr_pend_ff[SR_BP0]};
         end
      end else if (cs_rise && !wip_ff && state_ff == ST_IGNORE && bitcnt_ff == 3'h0 &&
                   nbytes_ff == 2'h0) begin
         if (op_ff == OP_WREN) wel_ff <= 1'b1;
         if (op_ff == OP_WRDI) wel_ff <= 1'b0;
      end
   end

   assign so_out = so_ff;
   assign so_oe_out = selected & hold_s & out_en_ff; // [RULE_03] [RULE_17]
   assign standby_out = cs_s & ~wip_ff; // [RULE_01] [RULE_02]
   assign busy_out = wip_ff;
   assign arr_addr_out = addr_ff[ADDR_W-1:0];
   assign arr_wdata_out = wdata_ff;
   assign arr_wr_out = arr_wr_ff;
   assign arr_commit_out = commit_ff;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_cap_rise;
      act_rise;
   endsequence
   sequence s_paused_edge;
      paused_ff && sck_rise && selected;
   endsequence

   property p_so_desel;
      cs_s |-> !so_oe_out;
   endproperty
   a_so_desel: assert property (p_so_desel) else $error("output driven while deselected"); // [RULE_03]
   property p_standby;
      cs_s && wip_ff |-> !standby_out;
   endproperty
   a_standby: assert property (p_standby) else $error("standby during write cycle"); // [RULE_02]
   property p_pause_hiz;
      !hold_s |-> !so_oe_out;
   endproperty
   a_pause_hiz: assert property (p_pause_hiz) else $error("output driven while paused"); // [RULE_17]
   property p_start;
      write_ok |=> wip_ff ##1 arr_commit_out == 1'b0;
   endproperty
   a_start: assert property (p_start) else $error("write cycle did not start"); // [RULE_04]
   property p_wc_len;
      $fell(wip_ff) |-> $past(wc_cnt_ff) == CNT_W'(WC_CYCLES - 1);
   endproperty
   a_wc_len: assert property (p_wc_len) else $error("write cycle length wrong"); // [RULE_05]
   property p_capture;
      s_cap_rise |=> rx_shift_ff[0] == $past(si_s);
   endproperty
   a_capture: assert property (p_capture) else $error("input bit not captured"); // [RULE_08]
   property p_ignore;
      s_paused_edge |=> $stable(bitcnt_ff) && $stable(rx_shift_ff);
   endproperty
   a_ignore: assert property (p_ignore) else $error("clock taken while paused"); // [RULE_15]
   property p_pause_now;
      selected && !sck_s && !hold_s && !cs_d_ff ##1 !cs_s |-> paused_ff;
   endproperty
   a_pause_now: assert property (p_pause_now) else $error("pause not applied"); // [RULE_13]
   property p_resume_now;
      paused_ff && !sck_s && hold_s && selected |=> !paused_ff;
   endproperty
   a_resume_now: assert property (p_resume_now) else $error("resume not applied"); // [RULE_14]
   property p_protect;
      cs_rise && protect_hit && op_ff == OP_WRSR && !wip_ff |=> !wip_ff;
   endproperty
   a_protect: assert property (p_protect) else $error("protected status write started"); // [RULE_09]
   property p_idle;
      cs_rise |=> state_ff == ST_INSTR && bitcnt_ff == 3'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("decoder not idle after deselect"); // [RULE_20]
endmodule

// *** testbench/epc_host.sv ***
/*
 Host controller model for the serial EEPROM front end: select, byte shifting, pause.
 Assumes the bench calls one task at a time and that so_line_in is the resolved wire.
*/
`timescale 1ns/1ns
module epc_host (
   input wire logic clk_in,
   input wire logic so_line_in,
   input wire logic so_oe_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic si_out,
   output logic hold_n_out,
   output logic wp_n_out
);
   logic [7:0] rx_byte;
   logic oe_p;
   logic oe_r;
   // Idle levels until the first frame: deselected, clock low, pause released.
   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
      hold_n_out = 1'b1;
      wp_n_out = 1'b1;
   end
   // Leaves room for the pin synchronisers before the first clock edge.
   task automatic sel();
      @(negedge clk_in);
      cs_n_out = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask
   // Protect pin level; the bench changes it only through this task, so one process drives it.
   task automatic set_wp(input logic v);
      wp_n_out = v;
   endtask
   // Ends with the clock low; the released data line shows a stale inverse.
   task automatic desel();
      sck_out = 1'b0;
      repeat (4) @(negedge clk_in);
      cs_n_out = 1'b1;
      si_out = ~si_out;
      repeat (4) @(negedge clk_in);
   endtask
   // Sends one byte and samples the reply late in each high phase, where it is settled.
   // A pause at bit pa wiggles clock and data, which the device has to ignore.
   task automatic xfer(input logic [7:0] tx, input int pa);
      for (int i = 7; i >= 0; i--) begin
         sck_out = 1'b0;
         si_out = tx[i];
         if (i == pa) begin
            repeat (3) @(negedge clk_in);
            hold_n_out = 1'b0;
            repeat (4) @(negedge clk_in);
            oe_p = so_oe_in;
            repeat (2) begin
               sck_out = ~sck_out;
               si_out = ~si_out;
               repeat (5) @(negedge clk_in);
            end
            si_out = tx[i];
            hold_n_out = 1'b1;
            repeat (4) @(negedge clk_in);
            oe_r = so_oe_in;
         end
         repeat (4) @(negedge clk_in);
         sck_out = 1'b1;
         repeat (4) @(negedge clk_in);
         rx_byte[i] = so_line_in;
      end
   endtask
endmodule

// *** testbench/testbench.sv ***
/*
 Self-checking bench for the serial EEPROM front end, driven through the host model.
 Assumes a shortened write cycle and an array whose byte is the low address byte xor A5.
*/
`timescale 1ns/1ns
module testbench;
   import epc_pkg::*;
   localparam int WC = 40;
   logic clk_sys_in, sys_rst_in, cs_n, sck, si, hold_n, wp_n, commit_seen;
   logic so_out, so_oe_out, standby_out, busy_out, arr_wr_out, arr_commit_out;
   logic [14:0] arr_addr_out;
   logic [7:0] arr_wdata_out, arr_rdata_in;
   logic [7:0] wq[$];
   wire so_line;
   int n_errors = 0;
   int samples_checked = 0;
   int busy_run = 0;
   // The serial output floats when not enabled, so a late sample never matches.
   assign so_line = so_oe_out ? so_out : 1'bz;
   assign arr_rdata_in = arr_addr_out[7:0] ^ 8'hA5;
   epc_front #(.WC_CYCLES(WC)) epc_front_inst (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
      .hold_n_in(hold_n), .wp_n_in(wp_n), .so_out(so_out), .so_oe_out(so_oe_out),
      .standby_out(standby_out), .busy_out(busy_out), .arr_addr_out(arr_addr_out),
      .arr_rdata_in(arr_rdata_in), .arr_wdata_out(arr_wdata_out),
      .arr_wr_out(arr_wr_out), .arr_commit_out(arr_commit_out));
   epc_host epc_host_inst (.clk_in(clk_sys_in), .so_line_in(so_line), .so_oe_in(so_oe_out),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .hold_n_out(hold_n), .wp_n_out(wp_n));
   // Clock at 100 ns.
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   // Collects page-buffer bytes and commit pulses, and counts busy cycles edge by edge
   // so the length is known even though the host sees the rise late.
   always @(posedge clk_sys_in) begin
      busy_run = (busy_out === 1'b1) ? busy_run + 1 : 0;
      if (arr_wr_out === 1'b1) wq.push_back(arr_wdata_out);
      if (arr_commit_out === 1'b1) commit_seen = 1'b1;
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic xb(input logic [7:0] tx);
      epc_host_inst.xfer(tx, -1);
   endtask
   task automatic cmd(input logic [7:0] op);
      epc_host_inst.sel();
      xb(op);
      epc_host_inst.desel();
   endtask
   task automatic wrsr(input logic [7:0] v);
      cmd(OP_WREN);
      epc_host_inst.sel();
      xb(OP_WRSR);
      xb(v);
      epc_host_inst.desel();
   endtask
   // Returns the status byte in the host model's receive byte.
   task automatic rdsr();
      epc_host_inst.sel();
      xb(OP_RDSR);
      xb(8'h00);
      epc_host_inst.desel();
   endtask
   // Waits a bounded time for the write cycle, then measures how long it stays busy.
   task automatic run_cycle(input logic go);
      int n = 0;
      while (busy_out !== 1'b1 && n < 20) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk("busy_start", {7'h0, go}, {7'h0, busy_out});
      if (busy_out === 1'b1) begin
         chk("standby_busy", 8'h00, {7'h0, standby_out});
         n = 0;
         while (busy_out === 1'b1 && n < WC + 10) begin
            @(negedge clk_sys_in);
            n++;
         end
         chk("busy_len", 8'(WC), 8'(busy_run));
      end
      repeat (4) @(negedge clk_sys_in);
      chk("standby_idle", 8'h01, {7'h0, standby_out});
   endtask
   task automatic t_write();
      wq.delete();
      commit_seen = 1'b0;
      cmd(OP_WREN);
      epc_host_inst.sel();
      chk("standby_sel", 8'h00, {7'h0, standby_out});
      xb(OP_WRITE);
      xb(8'h00);
      xb(8'h10);
      xb(8'hA1);
      xb(8'h5C);
      epc_host_inst.desel();
      run_cycle(1'b1);
      chk("commit", 8'h01, {7'h0, commit_seen});
      chk("wr_count", 8'h02, 8'(wq.size()));
      chk("wr_byte0", 8'hA1, wq[0]);
      chk("wr_byte1", 8'h5C, wq[1]);
   endtask
   // Second byte is paused mid-way while clock and data keep moving.
   task automatic t_read();
      epc_host_inst.sel();
      xb(OP_READ);
      xb(8'h00);
      xb(8'h10);
      xb(8'h00);
      chk("rd_byte0", 8'hB5, epc_host_inst.rx_byte);
      epc_host_inst.xfer(8'h00, 4);
      chk("rd_byte1", 8'hB4, epc_host_inst.rx_byte);
      chk("oe_paused", 8'h00, {7'h0, epc_host_inst.oe_p});
      chk("oe_resumed", 8'h01, {7'h0, epc_host_inst.oe_r});
      epc_host_inst.desel();
      chk("oe_desel", 8'h00, {7'h0, so_oe_out});
   endtask
   // A write cut short after the address must not start a cycle.
   task automatic t_abort();
      wq.delete();
      cmd(OP_WREN);
      epc_host_inst.sel();
      xb(OP_WRITE);
      xb(8'h00);
      xb(8'h20);
      epc_host_inst.desel();
      run_cycle(1'b0);
      chk("abort_bytes", 8'h00, 8'(wq.size()));
      rdsr();
      chk("abort_status", 8'h00, epc_host_inst.rx_byte & 8'h8D);
   endtask
   task automatic t_protect();
      epc_host_inst.set_wp(1'b0);
      commit_seen = 1'b0;
      wrsr(8'h80);
      run_cycle(1'b1);
      chk("no_commit", 8'h00, {7'h0, commit_seen});
      rdsr();
      chk("sr_honor", 8'h80, epc_host_inst.rx_byte & 8'h8C);
      wrsr(8'h0C);
      run_cycle(1'b0);
      rdsr();
      chk("sr_refused", 8'h80, epc_host_inst.rx_byte & 8'h8C);
      epc_host_inst.set_wp(1'b1);
      wrsr(8'h0C);
      epc_host_inst.set_wp(1'b0);
      run_cycle(1'b1);
      rdsr();
      chk("sr_kept", 8'h0C, epc_host_inst.rx_byte & 8'h8C);
      epc_host_inst.set_wp(1'b1);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Main sequence after a 12-cycle reset.
   initial begin
      sys_rst_in = 1'b1;
      repeat (12) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      chk("standby_rst", 8'h01, {7'h0, standby_out});
      chk("oe_rst", 8'h00, {7'h0, so_oe_out});
      t_write();
      t_read();
      t_abort();
      t_protect();
      results();
   end
   // The tests need about 2500 cycles; this bound leaves ample margin.
   initial begin
      repeat (30000) @(posedge clk_sys_in);
      n_errors++;
      $display("[FAIL] watchdog expected done seen timeout");
      results();
   end
endmodule
